// ===== sarc_map.svh
// Register map, field positions, reset values and timing counts of the converter control.
`ifndef SARC_MAP_SVH
`define SARC_MAP_SVH

`define SARC_RES_W          10
`define SARC_RES_PAD        6'h00

`define SARC_ADDR_RES_WIDE  16'hFF18
`define SARC_ADDR_RES_HI    16'hFF1F
`define SARC_ADDR_DIR       16'hFF22
`define SARC_ADDR_MODE      16'hFF2A
`define SARC_ADDR_CHAN      16'hFF2B
`define SARC_ADDR_PINCFG    16'hFF2D

`define SARC_MODE_CONV_EN   7
`define SARC_MODE_FR_MSB    5
`define SARC_MODE_FR_LSB    3
`define SARC_MODE_CMP_EN    0
`define SARC_MODE_MASK      8'hB9
`define SARC_CHAN_W         3
`define SARC_PINCFG_W       4
`define SARC_PINS           8

`define SARC_RST_MODE       8'h00
`define SARC_RST_CHAN       3'h0
`define SARC_RST_PINCFG     4'h0
`define SARC_RST_DIR        8'hFF
`define SARC_RST_RES_WIDE   16'h0000
`define SARC_RST_RES_HI     8'h00

`define SARC_DIV_T0         4'hC
`define SARC_DIV_T1         4'h8
`define SARC_DIV_T2         4'h6
`define SARC_DIV_T3         4'h4
`define SARC_DIV_T4         4'h3
`define SARC_DIV_T5         4'h2
`define SARC_TICKS_PER_CONV 5'd22
`define SARC_SAMPLE_TICKS   5'd2

`define SARC_CLK_PERIOD_NS  10
`define SARC_CMP_SETTLE_NS  1000
`define SARC_CMP_SETTLE_CYC \
  ((`SARC_CMP_SETTLE_NS + `SARC_CLK_PERIOD_NS - 1) / `SARC_CLK_PERIOD_NS)

`endif

// ===== sarc_pkg.sv
// Types shared by the converter control modules.
`include "sarc_map.svh"
package sarc_pkg;

  typedef enum logic [1:0] {
    SARC_STOPPED    = 2'b00,
    SARC_CMP_WAIT   = 2'b01,
    SARC_CONV_NOCMP = 2'b10,
    SARC_CONV_CMP   = 2'b11
  } sarc_mode_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sarc_bus_req_s;

  typedef struct packed {
    logic [`SARC_RES_W-1:0] dac;
    logic                   sample;
    logic                   done;
    logic [`SARC_RES_W-1:0] result;
  } sarc_core_out_s;

endpackage : sarc_pkg

// ===== sarc_sar_core.sv
// Conversion sequencer: clock divider, sampling and successive approximation.
module sarc_sar_core
  import sarc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic       i_restart,
  input  wire logic [2:0] i_time_sel,
  input  wire logic       i_cmp_high,
  output sarc_core_out_s  o_core
);

  localparam logic [`SARC_RES_W-1:0] MSB_ONEHOT =
    {1'b1, {(`SARC_RES_W-1){1'b0}}};

  logic [3:0]             presc_r, presc_nxt;
  logic [4:0]             tick_r, tick_nxt;
  logic [`SARC_RES_W-1:0] sar_r, sar_nxt;
  logic [`SARC_RES_W-1:0] bit_r, bit_nxt;
  sarc_core_out_s         out_r, out_nxt;
  logic [3:0]             div;
  logic                   tick_end;

  function automatic logic [3:0] time_div(input logic [2:0] sel);
    case (sel)
      3'h0:    time_div = `SARC_DIV_T0;
      3'h1:    time_div = `SARC_DIV_T1;
      3'h2:    time_div = `SARC_DIV_T2;
      3'h3:    time_div = `SARC_DIV_T3;
      3'h4:    time_div = `SARC_DIV_T4;
      3'h5:    time_div = `SARC_DIV_T5;
      default: time_div = `SARC_DIV_T0;
    endcase
  endfunction : time_div

  // Each conversion is 22 conversion clocks: two of sampling, then two per
  // bit. The decision is taken at the end of the second clock so that the
  // synchronised comparator level has settled on the new trial code.
  always_comb begin
    div       = time_div(i_time_sel);
    tick_end  = (presc_r == div - 4'h1);
    presc_nxt = tick_end ? 4'h0 : presc_r + 4'h1;
    tick_nxt  = tick_r;
    sar_nxt   = sar_r;
    bit_nxt   = bit_r;
    out_nxt   = out_r;
    out_nxt.done = 1'b0;
    if (!i_run || i_restart) begin
      presc_nxt = 4'h0;
      tick_nxt  = 5'd0;
      sar_nxt   = '0;
      bit_nxt   = '0;
    end else if (tick_end) begin
      if (tick_r == `SARC_SAMPLE_TICKS - 5'd1) begin
        bit_nxt = MSB_ONEHOT;
      end else if (tick_r >= `SARC_SAMPLE_TICKS && tick_r[0]) begin
        if (i_cmp_high) begin
          sar_nxt = sar_r | bit_r;
        end
        bit_nxt = bit_r >> 1;
      end
      if (tick_r == `SARC_TICKS_PER_CONV - 5'd1) begin
        tick_nxt       = 5'd0;
        out_nxt.done   = 1'b1;
        out_nxt.result = sar_r | (i_cmp_high ? bit_r : '0);
        sar_nxt        = '0;
      end else begin
        tick_nxt = tick_r + 5'd1;
      end
    end
    // A restart begins with sampling again, so tracking stays up through it.
    out_nxt.sample = i_run && (tick_nxt < `SARC_SAMPLE_TICKS);
    out_nxt.dac    = sar_nxt | bit_nxt;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      presc_r <= 4'h0;
      tick_r  <= 5'd0;
      sar_r   <= '0;
      bit_r   <= '0;
      out_r   <= '0;
    end else begin
      presc_r <= presc_nxt;
      tick_r  <= tick_nxt;
      sar_r   <= sar_nxt;
      bit_r   <= bit_nxt;
      out_r   <= out_nxt;
    end
  end

  assign o_core = out_r;

endmodule : sarc_sar_core

// ===== sarc_top.sv
// Register file and control of the eight-channel successive approximation converter.

// How it works
// - mode register holds enable, time select, comparator
// - conversion enable clear halts, set converts
// - two enables decode into four operating states
// - first result without settled comparator flagged untrusted
// - settled comparator makes first result trusted
// - time code selects divisor, 22 conversion clocks
// - wide result left aligned, low six zero
// - wide result loads each end, 16-bit read
// - upper byte result loads each end, byte read
// - result reads, control writes insert wait cycle
// - channel select low three bits pick input
// - pin count value makes lowest pins digital
// - direction register, one means input, resets ones
// - output-direction pin never acts as analog
// - continuous conversion, completion pulse per result
// - channel write restarts running conversion
// - clearing enable stops at once, keeps result
// - approximation resolves bit nine down to zero
module sarc_top
  import sarc_pkg::*;
(
  input  wire logic                     I_CLK,
  input  wire logic                     I_RST,
  input  sarc_bus_req_s                 I_BUS_REQ,
  input  wire logic                     I_CMP_HIGH,
  output logic [15:0]                   O_RDATA,
  output logic                          O_WAIT,
  output logic                          O_CONV_DONE_IRQ,
  output logic                          O_RESULT_TRUSTED,
  output logic                          O_CMP_POWER,
  output logic                          O_CONV_ACTIVE,
  output sarc_mode_e                    O_MODE_STATE,
  output logic [`SARC_RES_W-1:0]        O_DAC_CODE,
  output logic                          O_SAMPLE,
  output logic [`SARC_CHAN_W-1:0]       O_CHANNEL,
  output logic [`SARC_PINS-1:0]         O_ANALOG_EN,
  output logic [`SARC_PINS-1:0]         O_PIN_DIR
);

  // Comparator settling time in clock cycles. The age counter saturates at
  // this value, so eight bits cover any clock up to 250 MHz.
  localparam int SETTLE_CYC = `SARC_CMP_SETTLE_CYC;
  localparam logic [7:0] SETTLE_CNT = 8'(SETTLE_CYC);

  // Register file.
  logic [7:0]                 mode_r, mode_nxt;
  logic [`SARC_CHAN_W-1:0]    chan_r, chan_nxt;
  logic [`SARC_PINCFG_W-1:0]  pincfg_r, pincfg_nxt;
  logic [`SARC_PINS-1:0]      dir_r, dir_nxt;
  logic [15:0]                rdata_r, rdata_nxt;
  logic                       wait_r, wait_nxt;
  logic                       restart_r, restart_nxt;

  // Results and completion.
  logic [15:0]                res_wide_r, res_wide_nxt;
  logic [7:0]                 res_hi_r, res_hi_nxt;
  logic                       irq_r, irq_nxt;
  logic                       trusted_r, trusted_nxt;
  logic                       first_bad_r, first_bad_nxt;

  // Comparator power, settling and decoded pin use.
  logic [7:0]                 age_r, age_nxt;
  logic                       power_r, power_nxt;
  sarc_mode_e                 state_r, state_nxt;
  logic [`SARC_PINS-1:0]      analog_r, analog_nxt;

  // Comparator level synchroniser.
  logic                       cmp_s1_r, cmp_s2_r, cmp_s3_r;
  logic                       cmp_filt_r, cmp_filt_nxt;

  sarc_core_out_s             core;
  logic                       wr_mode, wr_chan, wr_pincfg, wr_dir;
  logic                       rd_wide, rd_hi;

  function automatic logic [`SARC_PINS-1:0] analog_pins(
    input logic [`SARC_PINCFG_W-1:0] cfg,
    input logic [`SARC_PINS-1:0]     dir
  );
    logic [`SARC_PINS-1:0] m;
    m = '0;
    for (int i = 0; i < `SARC_PINS; i++) begin
      // Values above eight leave every pin digital.
      m[i] = (4'(i) >= cfg) && dir[i];
    end
    analog_pins = m;
  endfunction : analog_pins

  function automatic sarc_mode_e decode_mode(input logic [7:0] mode);
    case ({mode[`SARC_MODE_CONV_EN], mode[`SARC_MODE_CMP_EN]})
      2'b00:   decode_mode = SARC_STOPPED;
      2'b01:   decode_mode = SARC_CMP_WAIT;
      2'b10:   decode_mode = SARC_CONV_NOCMP;
      2'b11:   decode_mode = SARC_CONV_CMP;
      default: decode_mode = SARC_STOPPED;
    endcase
  endfunction : decode_mode

  // Addresses are compared in full, so no register answers at an alias
  // elsewhere in the map.
  always_comb begin
    wr_mode   = I_BUS_REQ.wr && (I_BUS_REQ.addr == `SARC_ADDR_MODE);
    wr_chan   = I_BUS_REQ.wr && (I_BUS_REQ.addr == `SARC_ADDR_CHAN);
    wr_pincfg = I_BUS_REQ.wr && (I_BUS_REQ.addr == `SARC_ADDR_PINCFG);
    wr_dir    = I_BUS_REQ.wr && (I_BUS_REQ.addr == `SARC_ADDR_DIR);
    rd_wide   = I_BUS_REQ.rd && I_BUS_REQ.wide &&
                (I_BUS_REQ.addr == `SARC_ADDR_RES_WIDE);
    rd_hi     = I_BUS_REQ.rd && !I_BUS_REQ.wide &&
                (I_BUS_REQ.addr == `SARC_ADDR_RES_HI);
  end

  // Register writes, reads and the wait cycle.
  always_comb begin
    mode_nxt    = mode_r;
    chan_nxt    = chan_r;
    pincfg_nxt  = pincfg_r;
    dir_nxt     = dir_r;
    rdata_nxt   = rdata_r;
    restart_nxt = 1'b0;
    if (wr_mode) begin
      mode_nxt = I_BUS_REQ.wdata & `SARC_MODE_MASK;
    end
    if (wr_chan) begin
      chan_nxt    = I_BUS_REQ.wdata[`SARC_CHAN_W-1:0];
      // A channel write while running restarts the sequence from sampling.
      restart_nxt = mode_r[`SARC_MODE_CONV_EN];
    end
    if (wr_pincfg) begin
      pincfg_nxt = I_BUS_REQ.wdata[`SARC_PINCFG_W-1:0];
    end
    if (wr_dir) begin
      dir_nxt = I_BUS_REQ.wdata;
    end
    // Read data is held until the next read, so a slow processor can take
    // it at leisure.
    if (I_BUS_REQ.rd) begin
      case (I_BUS_REQ.addr)
        `SARC_ADDR_RES_WIDE:
          rdata_nxt = I_BUS_REQ.wide ? res_wide_r : 16'h0000;
        `SARC_ADDR_RES_HI:
          rdata_nxt = I_BUS_REQ.wide ? 16'h0000 : {8'h00, res_hi_r};
        `SARC_ADDR_DIR:    rdata_nxt = {8'h00, dir_r};
        `SARC_ADDR_MODE:   rdata_nxt = {8'h00, mode_r};
        `SARC_ADDR_CHAN:   rdata_nxt = {13'h0000, chan_r};
        `SARC_ADDR_PINCFG: rdata_nxt = {12'h000, pincfg_r};
        default:           rdata_nxt = 16'h0000;
      endcase
    end
    // The access itself is never stalled; the wait cycle is reported as a
    // one-cycle pulse after the access for the processor side to honour.
    wait_nxt = rd_wide || rd_hi || wr_mode || wr_chan || wr_pincfg;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mode_r    <= `SARC_RST_MODE;
      chan_r    <= `SARC_RST_CHAN;
      pincfg_r  <= `SARC_RST_PINCFG;
      dir_r     <= `SARC_RST_DIR;
      rdata_r   <= 16'h0000;
      wait_r    <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      chan_r    <= chan_nxt;
      pincfg_r  <= pincfg_nxt;
      dir_r     <= dir_nxt;
      rdata_r   <= rdata_nxt;
      wait_r    <= wait_nxt;
      restart_r <= restart_nxt;
    end
  end

  // The comparator level is asynchronous to the peripheral clock. A change
  // is taken only once the second and third stages agree, which costs one
  // cycle of latency but keeps a metastable first stage out of decisions.
  always_comb begin
    cmp_filt_nxt = (cmp_s2_r == cmp_s3_r) ? cmp_s3_r : cmp_filt_r;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cmp_s1_r   <= 1'b0;
      cmp_s2_r   <= 1'b0;
      cmp_s3_r   <= 1'b0;
      cmp_filt_r <= 1'b0;
    end else begin
      cmp_s1_r   <= I_CMP_HIGH;
      cmp_s2_r   <= cmp_s1_r;
      cmp_s3_r   <= cmp_s2_r;
      cmp_filt_r <= cmp_filt_nxt;
    end
  end

  sarc_sar_core u_core (
    .i_clk      (I_CLK),
    .i_rst      (I_RST),
    .i_run      (mode_r[`SARC_MODE_CONV_EN]),
    .i_restart  (restart_r),
    .i_time_sel (mode_r[`SARC_MODE_FR_MSB:`SARC_MODE_FR_LSB]),
    .i_cmp_high (cmp_filt_nxt),
    .o_core     (core)
  );

  // The comparator runs whenever either enable is set. Its age is counted
  // from power-up so that the first result can be judged at start time.
  always_comb begin
    power_nxt = mode_nxt[`SARC_MODE_CONV_EN] | mode_nxt[`SARC_MODE_CMP_EN];
    if (!power_r) begin
      age_nxt = 8'h00;
    end else if (age_r < SETTLE_CNT) begin
      age_nxt = age_r + 8'h01;
    end else begin
      age_nxt = age_r;
    end
    state_nxt  = decode_mode(mode_nxt);
    analog_nxt = analog_pins(pincfg_nxt, dir_nxt);
  end

  // Pin use follows a write at the same edge as the registers themselves.
  // During reset it reads zero, so no pin is taken as analog too early.
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      age_r    <= 8'h00;
      power_r  <= 1'b0;
      state_r  <= SARC_STOPPED;
      analog_r <= '0;
    end else begin
      age_r    <= age_nxt;
      power_r  <= power_nxt;
      state_r  <= state_nxt;
      analog_r <= analog_nxt;
    end
  end

  // Result capture. Clearing the enable leaves the stored result alone.
  always_comb begin
    res_wide_nxt  = res_wide_r;
    res_hi_nxt    = res_hi_r;
    trusted_nxt   = trusted_r;
    first_bad_nxt = first_bad_r;
    irq_nxt       = core.done;
    if (core.done) begin
      res_wide_nxt  = {core.result, `SARC_RES_PAD};
      res_hi_nxt    = core.result[`SARC_RES_W-1:`SARC_RES_W-8];
      trusted_nxt   = !first_bad_r;
      first_bad_nxt = 1'b0;
    end
    // A fresh start judges the comparator age now. A completion of the run
    // just stopped can land in the same cycle; the start then wins, since
    // its own first result is the one still to come.
    if (wr_mode && I_BUS_REQ.wdata[`SARC_MODE_CONV_EN] &&
        !mode_r[`SARC_MODE_CONV_EN]) begin
      first_bad_nxt = !(mode_r[`SARC_MODE_CMP_EN] &&
                        (age_r >= SETTLE_CNT));
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      res_wide_r  <= `SARC_RST_RES_WIDE;
      res_hi_r    <= `SARC_RST_RES_HI;
      trusted_r   <= 1'b0;
      first_bad_r <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      res_wide_r  <= res_wide_nxt;
      res_hi_r    <= res_hi_nxt;
      trusted_r   <= trusted_nxt;
      first_bad_r <= first_bad_nxt;
      irq_r       <= irq_nxt;
    end
  end

  // Every output below is a register; none is decoded after a flop.
  assign O_RDATA          = rdata_r;
  assign O_WAIT           = wait_r;
  assign O_CONV_DONE_IRQ  = irq_r;
  assign O_RESULT_TRUSTED = trusted_r;
  assign O_CMP_POWER      = power_r;
  assign O_CONV_ACTIVE    = mode_r[`SARC_MODE_CONV_EN];
  assign O_MODE_STATE     = state_r;
  assign O_DAC_CODE       = core.dac;
  assign O_SAMPLE         = core.sample;
  assign O_CHANNEL        = chan_r;
  assign O_ANALOG_EN      = analog_r;
  assign O_PIN_DIR        = dir_r;

endmodule : sarc_top

// ===== sarc_props.sv
// Concurrent checks on the ports of the converter control top.
`include "sarc_map.svh"
module sarc_props
  import sarc_pkg::*;
(
  input wire logic              I_CLK,
  input wire logic              I_RST,
  input sarc_bus_req_s          I_BUS_REQ,
  input wire logic [15:0]       O_RDATA,
  input wire logic              O_WAIT,
  input wire logic              O_CONV_DONE_IRQ,
  input wire logic              O_CMP_POWER,
  input wire logic              O_CONV_ACTIVE,
  input sarc_mode_e             O_MODE_STATE,
  input wire logic              O_SAMPLE,
  input wire logic [2:0]        O_CHANNEL,
  input wire logic [7:0]        O_ANALOG_EN,
  input wire logic [7:0]        O_PIN_DIR
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  a_wait_ctl_wr: assert property (I_BUS_REQ.wr && (I_BUS_REQ.addr ==
    `SARC_ADDR_MODE || I_BUS_REQ.addr == `SARC_ADDR_CHAN ||
    I_BUS_REQ.addr == `SARC_ADDR_PINCFG) |=> O_WAIT)
    else $error("no wait after control write");
  a_wait_res_rd: assert property (I_BUS_REQ.rd && I_BUS_REQ.wide &&
    I_BUS_REQ.addr == `SARC_ADDR_RES_WIDE |=> O_WAIT)
    else $error("no wait after result read");
  a_mode_enable: assert property (I_BUS_REQ.wr &&
    I_BUS_REQ.addr == `SARC_ADDR_MODE
    |=> O_CONV_ACTIVE == $past(I_BUS_REQ.wdata[7]))
    else $error("conversion enable does not follow write");
  a_state_decode: assert property (O_MODE_STATE[1] == O_CONV_ACTIVE &&
    O_CMP_POWER == (O_MODE_STATE != SARC_STOPPED))
    else $error("operating state decode wrong");
  a_wide_pad: assert property (I_BUS_REQ.rd && I_BUS_REQ.wide &&
    I_BUS_REQ.addr == `SARC_ADDR_RES_WIDE |=> O_RDATA[5:0] == 6'h00)
    else $error("wide result low bits not zero");
  a_irq_pulse: assert property (O_CONV_DONE_IRQ |=> !O_CONV_DONE_IRQ)
    else $error("completion pulse longer than one cycle");
  a_irq_resample: assert property (O_CONV_DONE_IRQ && O_CONV_ACTIVE
    |-> O_SAMPLE)
    else $error("next conversion not started at completion");
  a_stop_quiet: assert property (!O_CONV_ACTIVE && !$past(O_CONV_ACTIVE)
    |-> !O_CONV_DONE_IRQ)
    else $error("completion while stopped");
  a_analog_dir: assert property ((O_ANALOG_EN & ~O_PIN_DIR) == 8'h00)
    else $error("output pin marked analog");
  a_chan_write: assert property (I_BUS_REQ.wr &&
    I_BUS_REQ.addr == `SARC_ADDR_CHAN
    |=> O_CHANNEL == $past(I_BUS_REQ.wdata[2:0]))
    else $error("channel does not follow write");
  a_dir_write: assert property (I_BUS_REQ.wr &&
    I_BUS_REQ.addr == `SARC_ADDR_DIR
    |=> O_PIN_DIR == $past(I_BUS_REQ.wdata))
    else $error("direction does not follow write");
endmodule : sarc_props

bind sarc_top sarc_props u_props (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_BUS_REQ(I_BUS_REQ), .O_RDATA(O_RDATA), .O_WAIT(O_WAIT),
  .O_CONV_DONE_IRQ(O_CONV_DONE_IRQ), .O_CMP_POWER(O_CMP_POWER),
  .O_CONV_ACTIVE(O_CONV_ACTIVE), .O_MODE_STATE(O_MODE_STATE),
  .O_SAMPLE(O_SAMPLE), .O_CHANNEL(O_CHANNEL),
  .O_ANALOG_EN(O_ANALOG_EN), .O_PIN_DIR(O_PIN_DIR));

// ===== sarc_cmp_model.sv
// Behavioural comparator front end with sample and hold.
module sarc_cmp_model (
  input  wire logic       i_clk,
  input  wire logic       i_sample,
  input  wire logic [9:0] i_dac,
  input  wire logic [9:0] i_vin,
  output logic            o_cmp_high
);
  timeunit 1ns;
  timeprecision 1ns;
  // The input is frozen while tracking ends, so later changes of the
  // analog level cannot leak into a conversion already under way.
  logic [9:0] held_r = 10'h000;
  always_ff @(posedge i_clk) begin
    if (i_sample) held_r <= i_vin;
  end
  assign o_cmp_high = (held_r >= i_dac);
endmodule : sarc_cmp_model

// ===== sarc_tb.sv
// Self-checking bench for the converter control block.
`include "sarc_map.svh"
module testbench;
  import sarc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, cmp_high, wait_o, irq, trusted, smp;
  logic cmp_pwr, active, wait_v;
  sarc_bus_req_s bus = '0;
  sarc_mode_e mstate;
  logic [15:0] rdata, rd_v;
  logic [9:0] dac, vin = 10'h000;
  logic [2:0] chan;
  logic [7:0] aen, pdir;
  int error_cnt = 0, n_checks = 0, n;
  int divs[6] = '{12, 8, 6, 4, 3, 2};
  logic [9:0] vins[6] = '{10'h3FF, 10'h000, 10'h155, 10'h2AA, 10'h200,
                          10'h1FF};
  logic [15:0] ra[7] = '{`SARC_ADDR_MODE, `SARC_ADDR_CHAN, `SARC_ADDR_PINCFG,
                         `SARC_ADDR_DIR, `SARC_ADDR_RES_WIDE,
                         `SARC_ADDR_RES_HI, 16'hFF30};
  logic [15:0] rv[7] = '{16'h0000, 16'h0000, 16'h0000, 16'h00FF, 16'h0000,
                         16'h0000, 16'h0000};
  logic [7:0] mw[4] = '{8'h01, 8'h80, 8'h81, 8'h00};
  sarc_mode_e ms[4] = '{SARC_CMP_WAIT, SARC_CONV_NOCMP, SARC_CONV_CMP,
                        SARC_STOPPED};

  sarc_top dut (.I_CLK(clk), .I_RST(rst), .I_BUS_REQ(bus),
    .I_CMP_HIGH(cmp_high), .O_RDATA(rdata), .O_WAIT(wait_o),
    .O_CONV_DONE_IRQ(irq), .O_RESULT_TRUSTED(trusted), .O_CMP_POWER(cmp_pwr),
    .O_CONV_ACTIVE(active), .O_MODE_STATE(mstate), .O_DAC_CODE(dac),
    .O_SAMPLE(smp), .O_CHANNEL(chan), .O_ANALOG_EN(aen), .O_PIN_DIR(pdir));
  sarc_cmp_model u_cmp (.i_clk(clk), .i_sample(smp), .i_dac(dac),
    .i_vin(vin), .o_cmp_high(cmp_high));

  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One request stands for exactly one sampling edge.
  task automatic access(input logic rd, input logic wr, input logic wide,
                        input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{rd: rd, wr: wr, wide: wide, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
    #1;
    rd_v = rdata;
    wait_v = wait_o;
  endtask : access

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    access(1'b0, 1'b1, 1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    access(1'b1, 1'b0, a == `SARC_ADDR_RES_WIDE, a, 8'h00);
  endtask : rd

  task automatic wait_irq(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
      #1;
    end while (irq !== 1'b1 && cnt < lim);
  endtask : wait_irq

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wr(`SARC_ADDR_RES_WIDE, 8'hAA);
    for (int i = 0; i < 7; i++) begin
      rd(ra[i]);
      chk("reset value", rv[i], rd_v);
    end
    rd(`SARC_ADDR_RES_WIDE);
    chk("wide result wait", 16'h0001, {15'h0000, wait_v});
    chk("pin direction out", 16'h00FF, {8'h00, pdir});
    wr(`SARC_ADDR_MODE, 8'hFF);
    chk("mode write wait", 16'h0001, {15'h0000, wait_v});
    rd(`SARC_ADDR_MODE);
    chk("mode fixed bits", 16'h00B9, rd_v);
    wr(`SARC_ADDR_MODE, 8'h38);
    wr(`SARC_ADDR_CHAN, 8'h07);
    rd(`SARC_ADDR_CHAN);
    chk("chan fixed bits", 16'h0007, rd_v);
    wr(`SARC_ADDR_PINCFG, 8'hFF);
    rd(`SARC_ADDR_PINCFG);
    chk("pincfg bits", 16'h000F, rd_v);
    $display("test registers done");
    for (int i = 0; i <= 8; i++) begin
      wr(`SARC_ADDR_PINCFG, 8'(i));
      repeat (2) @(posedge clk);
      #1;
      chk("analog pins", {8'h00, 8'(8'hFF << i)}, {8'h00, aen});
    end
    wr(`SARC_ADDR_PINCFG, 8'h00);
    wr(`SARC_ADDR_DIR, 8'h0F);
    chk("dir write wait", 16'h0000, {15'h0000, wait_v});
    repeat (2) @(posedge clk);
    #1;
    chk("output pins not analog", 16'h000F, {8'h00, aen});
    wr(`SARC_ADDR_DIR, 8'hFF);
    $display("test pins done");
    for (int i = 0; i < 4; i++) begin
      wr(`SARC_ADDR_MODE, mw[i]);
      chk("mode state", {14'h0000, ms[i]}, {14'h0000, mstate});
    end
    vin = 10'h2C3;
    wr(`SARC_ADDR_MODE, 8'h81);
    wait_irq(400, n);
    chk("first result untrusted", 16'h0000, {15'h0000, trusted});
    wait_irq(400, n);
    chk("later result trusted", 16'h0001, {15'h0000, trusted});
    vin = 10'h011;
    repeat (100) @(posedge clk);
    wr(`SARC_ADDR_MODE, 8'h01);
    wait_irq(600, n);
    chk("no completion stopped", 16'd600, 16'(n));
    rd(`SARC_ADDR_RES_HI);
    chk("result kept", 16'h00B0, rd_v);
    $display("test states done");
    // At this clock every code puts the conversion clock far above its
    // analog limit; counts, results and trust are checked, the comparator is ideal.
    for (int c = 0; c < 6; c++) begin
      vin = vins[c];
      wr(`SARC_ADDR_MODE, {2'b00, 3'(c > 0 ? c - 1 : 0), 3'b001});
      wr(`SARC_ADDR_MODE, {2'b00, 3'(c), 3'b001});
      repeat (`SARC_CMP_SETTLE_CYC + 10) @(posedge clk);
      wr(`SARC_ADDR_MODE, {2'b10, 3'(c), 3'b001});
      wait_irq(400, n);
      chk("first completion", 16'(22 * divs[c] + 1), 16'(n));
      chk("settled result trusted", 16'h0001, {15'h0000, trusted});
      wait_irq(400, n);
      chk("repeat period", 16'(22 * divs[c]), 16'(n));
      rd(`SARC_ADDR_RES_WIDE);
      chk("wide result", {vins[c], 6'h00}, rd_v);
      rd(`SARC_ADDR_RES_HI);
      chk("upper byte", {8'h00, vins[c][9:2]}, rd_v);
      chk("byte result wait", 16'h0001, {15'h0000, wait_v});
    end
    $display("test conversion times done");
    wait_irq(400, n);
    repeat (20) @(posedge clk);
    wr(`SARC_ADDR_CHAN, 8'h03);
    chk("channel out", 16'h0003, {13'h0000, chan});
    wait_irq(400, n);
    chk("restart length", 16'(22 * 2 + 2), 16'(n));
    $display("test channel restart done");
    give_verdict();
  end
endmodule : testbench
